// file: dac_cal_pkg.sv
// Purpose: Shared constants and types for the dual converter calibration
//          and trim control block.
// Assumes: One 20 MHz converter clock; registers reached over a 3-wire
//          serial port.
// Notes:   Register offsets are the serial port byte addresses.
package dac_cal_pkg;

	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;

	localparam logic [6:0] REG_I_FINE_GAIN   = 7'h03;
	localparam logic [6:0] REG_I_COARSE_GAIN = 7'h04;
	localparam logic [6:0] REG_I_CM_RES      = 7'h05;
	localparam logic [6:0] REG_Q_FINE_GAIN   = 7'h06;
	localparam logic [6:0] REG_Q_COARSE_GAIN = 7'h07;
	localparam logic [6:0] REG_Q_CM_RES      = 7'h08;
	localparam logic [6:0] REG_REF_TRIM      = 7'h0D;
	localparam logic [6:0] REG_CAL_CONTROL   = 7'h0E;
	localparam logic [6:0] REG_CAL_STATUS    = 7'h0F;
	localparam logic [6:0] REG_COEF_ADDRESS  = 7'h10;
	localparam logic [6:0] REG_COEF_DATA     = 7'h11;
	localparam logic [6:0] REG_CAL_MEM_CTRL  = 7'h12;

	localparam logic [7:0] REG_RESET = 8'h00;

	// Field positions
	localparam int CTRL_DIV_MSB      = 2;
	localparam int CTRL_CLK_EN_BIT   = 3;
	localparam int CTRL_SEL_I_BIT    = 4;
	localparam int CTRL_SEL_Q_BIT    = 5;
	localparam int STAT_DONE_I_BIT   = 6;
	localparam int STAT_DONE_Q_BIT   = 7;
	localparam int MEM_UNCAL_I_BIT   = 0;
	localparam int MEM_UNCAL_Q_BIT   = 1;
	localparam int MEM_READ_BIT      = 2;
	localparam int MEM_WRITE_BIT     = 3;
	localparam int MEM_START_BIT     = 4;
	localparam int CM_CONNECT_BIT    = 6;
	localparam int CODE_W            = 6;

	// Coefficient store
	localparam int COEF_COUNT = 32;
	localparam int COEF_W     = 6;
	localparam int COEF_IDX_W = 5;
	localparam logic [7:0] COEF_FIRST_ADDR = 8'h01;
	localparam logic [7:0] COEF_LAST_ADDR  = 8'h20;
	localparam logic [5:0] COEF_MIDSCALE   = 6'h20;

	// Calibration clock divider, in converter clock cycles
	localparam logic [11:0] DIV_MIN_CYCLES = 12'h020;
	localparam logic [11:0] DIV_MAX_CYCLES = 12'h800;
	localparam logic [2:0]  DIV_SEL_MAX    = 3'h6;

	// Calibration run length and store window, in calibration clock ticks
	localparam logic [8:0] CAL_TICKS       = 9'h12C;
	localparam logic [8:0] CAL_STORE_TICKS = 9'h100;

	// Serial frame: R/W flag, 7-bit address, 8-bit data
	localparam logic [4:0] SPI_HEADER_BITS = 5'h08;
	localparam logic [4:0] SPI_FRAME_BITS  = 5'h10;

	typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_DONE} cal_state_t;

	// Period of one calibration clock for a divider select value
	function automatic logic [11:0] div_period(input logic [2:0] sel);
		if (sel >= DIV_SEL_MAX)
			return DIV_MAX_CYCLES;
		return DIV_MIN_CYCLES << sel;
	endfunction

endpackage

// file: cal_engine.sv
// Purpose: Self-calibration engine for one converter channel.
// Assumes: cal_tick_in is a one-cycle enable from the divider; comparator
//          input already synchronised.
// Notes:   Stores 32 coefficients over the first 256 ticks of a run.
`timescale 1ns/100ps
module cal_engine
(
	input  wire logic                        clk_in,
	input  wire logic                        rstn_in,
	input  wire logic                        cal_tick_in,
	input  wire logic                        start_in,
	input  wire logic                        select_in,
	input  wire logic                        comparator_in,
	output logic                             busy_out,
	output logic                             done_out,
	output logic                             abort_out,
	output logic                             coef_wr_out,
	output logic [dac_cal_pkg::COEF_IDX_W-1:0] coef_idx_out,
	output logic [dac_cal_pkg::COEF_W-1:0]   coef_data_out
);
	import dac_cal_pkg::*;

	cal_state_t        state_reg;
	cal_state_t        state_next;
	logic [8:0]        tick_cnt_reg;
	logic [8:0]        tick_cnt_next;
	logic [COEF_W-1:0] acc_reg;
	logic [COEF_W-1:0] acc_next;

	always_comb
	begin
		state_next    = state_reg;
		tick_cnt_next = tick_cnt_reg;
		acc_next      = acc_reg;
		abort_out     = 1'b0;
		coef_wr_out   = 1'b0;
		coef_idx_out  = tick_cnt_reg[7:3];
		coef_data_out = acc_reg;
		case (state_reg)
			CAL_IDLE:
				if (start_in && select_in)
				begin
					state_next    = CAL_RUN;
					tick_cnt_next = 9'h000;
					acc_next      = COEF_MIDSCALE;
				end
			CAL_RUN:
				if (!start_in)
				begin
					state_next = CAL_IDLE;
					abort_out  = 1'b1;
				end
				else if (cal_tick_in)
				begin
					if (comparator_in && acc_reg != 6'h3F)
						acc_next = acc_reg + 6'h01;
					else if (!comparator_in && acc_reg != 6'h00)
						acc_next = acc_reg - 6'h01;
					tick_cnt_next = tick_cnt_reg + 9'h001;
					if (tick_cnt_reg[2:0] == 3'h7
						&& tick_cnt_reg < CAL_STORE_TICKS)
					begin
						coef_wr_out   = 1'b1;
						coef_data_out = acc_next;
					end
					if (tick_cnt_reg == CAL_TICKS - 9'h001)
						state_next = CAL_DONE;
				end
			CAL_DONE:
				if (!start_in)
					state_next = CAL_IDLE;
			default:
				state_next = CAL_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			state_reg    <= CAL_IDLE;
			tick_cnt_reg <= 9'h000;
			acc_reg      <= 6'h00;
		end
		else
		begin
			state_reg    <= state_next;
			tick_cnt_reg <= tick_cnt_next;
			acc_reg      <= acc_next;
		end
	end

	assign busy_out = (state_reg == CAL_RUN);
	assign done_out = (state_reg == CAL_DONE);

	// Tick count of the current run, seen only by the checks below
	logic [9:0] run_ticks_reg;
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			run_ticks_reg <= 10'h000;
		else if (state_reg == CAL_IDLE)
			run_ticks_reg <= 10'h000;
		else if (busy_out && cal_tick_in)
			run_ticks_reg <= run_ticks_reg + 10'h001;
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	property p_done_after_300;
		$rose(done_out) |-> run_ticks_reg == 10'h12C;
	endproperty
	a_done_after_300: assert property (p_done_after_300)
		else $error("Done reached without 300 ticks");

	property p_done_holds;
		done_out && start_in |=> done_out;
	endproperty
	a_done_holds: assert property (p_done_holds)
		else $error("Done dropped while start still set");

	property p_pause_no_tick;
		busy_out && start_in && !cal_tick_in
			|=> $stable(tick_cnt_reg) && $stable(acc_reg);
	endproperty
	a_pause_no_tick: assert property (p_pause_no_tick)
		else $error("Engine advanced without a tick");

	property p_store_on_tick;
		coef_wr_out |-> cal_tick_in && busy_out;
	endproperty
	a_store_on_tick: assert property (p_store_on_tick)
		else $error("Coefficient stored outside a tick");

	property p_start_needs_select;
		$rose(busy_out) |-> $past(select_in) && $past(start_in);
	endproperty
	a_start_needs_select: assert property (p_start_needs_select)
		else $error("Run began on an unselected channel");

	c_run_done: cover property ($rose(done_out));
endmodule

// file: dac_cal_ctrl.sv
// Function
// - Calibration clock divided by three-bit select
// - Calibration period 32 to 2048 clocks
// - Independent engine per channel
// - Calibration clock runs only when enabled
// - Bits 4/5 select I and Q
// - Start bit runs calibration, about 300 ticks
// - Done flags in status bits 6, 7
// - Writing zero clears flags and controls; a zero write that stops a run sets the uncalibrated flags
// - 32 read/write coefficients per channel
// - Address register, first coefficient at 0x01
// - Read bit exposes selected coefficient
// - Write bit stores data at address
// - Six-bit signed reference trim
// - Six-bit signed coarse gain per channel
// - Six-bit binary fine gain per channel
// - Common-mode resistor off after reset
//
// Purpose: Register file, serial port, divider and coefficient store.
// Assumes: ref_clk_in is the converter clock; pins are asynchronous.
// Notes:   Serial frame is 16 bits, MSB first, read flag first.
`timescale 1ns/100ps
module dac_cal_ctrl
(
	input  wire logic                    ref_clk_in,
	input  wire logic                    rstn_in,
	input  wire logic                    spi_cs_n_in,
	input  wire logic                    spi_sclk_in,
	input  wire logic                    spi_sdio_in,
	output logic                         spi_sdio_out,
	output logic                         spi_sdio_oe_out,
	input  wire logic                    cal_compare_i_in,
	input  wire logic                    cal_compare_q_in,
	output logic [dac_cal_pkg::CODE_W-1:0] i_fine_gain_code_out,
	output logic [dac_cal_pkg::CODE_W-1:0] i_coarse_gain_code_out,
	output logic [dac_cal_pkg::CODE_W-1:0] i_common_mode_res_code_out,
	output logic                         i_common_mode_res_connect_out,
	output logic [dac_cal_pkg::CODE_W-1:0] q_fine_gain_code_out,
	output logic [dac_cal_pkg::CODE_W-1:0] q_coarse_gain_code_out,
	output logic [dac_cal_pkg::CODE_W-1:0] q_common_mode_res_code_out,
	output logic                         q_common_mode_res_connect_out,
	output logic [dac_cal_pkg::CODE_W-1:0] reference_trim_code_out
);
	import dac_cal_pkg::*;

	// Pin synchronisers: cs_n, sclk, sdio, compare I, compare Q
	logic [4:0] sync1_reg;
	logic [4:0] sync2_reg;
	logic       sclk_d3_reg;
	logic       cs_n_s;
	logic       sclk_s;
	logic       sdio_s;
	logic       sclk_rise;
	logic       sclk_fall;

	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			sync1_reg   <= 5'h01;
			sync2_reg   <= 5'h01;
			sclk_d3_reg <= 1'b0;
		end
		else
		begin
			sync1_reg   <= {cal_compare_q_in, cal_compare_i_in,
				spi_sdio_in, spi_sclk_in, spi_cs_n_in};
			sync2_reg   <= sync1_reg;
			sclk_d3_reg <= sync2_reg[1];
		end
	end

	assign cs_n_s    = sync2_reg[0];
	assign sclk_s    = sync2_reg[1];
	assign sdio_s    = sync2_reg[2];
	assign sclk_rise = sclk_s && !sclk_d3_reg;
	assign sclk_fall = !sclk_s && sclk_d3_reg;

	// Registers
	logic [7:0] i_fine_reg,   i_fine_next;
	logic [7:0] i_coarse_reg, i_coarse_next;
	logic [7:0] i_cm_reg,     i_cm_next;
	logic [7:0] q_fine_reg,   q_fine_next;
	logic [7:0] q_coarse_reg, q_coarse_next;
	logic [7:0] q_cm_reg,     q_cm_next;
	logic [7:0] trim_reg,     trim_next;
	logic [7:0] cal_ctrl_reg, cal_ctrl_next;
	logic [7:0] coef_addr_reg, coef_addr_next;
	logic [4:0] mem_ctrl_reg, mem_ctrl_next;

	// Serial port state
	logic [4:0] bit_cnt_reg,  bit_cnt_next;
	logic [6:0] shift_reg,    shift_next;
	logic [6:0] addr_reg,     addr_next;
	logic       rd_reg,       rd_next;
	logic [7:0] tx_reg,       tx_next;
	logic       sdo_reg,      sdo_next;
	logic       oe_reg,       oe_next;
	logic       wr_stb;
	logic [7:0] wr_data;

	// Divider and engines
	logic [10:0] div_cnt_reg, div_cnt_next;
	logic        cal_tick;
	logic [11:0] period;
	logic        done_i, done_q, abort_i, abort_q;
	logic        eng_wr_i, eng_wr_q;
	logic [COEF_IDX_W-1:0] eng_idx_i, eng_idx_q;
	logic [COEF_W-1:0]     eng_data_i, eng_data_q;

	// Coefficient store, one array per channel
	logic [COEF_W-1:0] coef_i_mem [COEF_COUNT];
	logic [COEF_W-1:0] coef_q_mem [COEF_COUNT];
	logic                  coef_addr_ok;
	logic [COEF_IDX_W-1:0] coef_idx;
	logic                  host_wr_i, host_wr_q;

	assign coef_addr_ok = coef_addr_reg >= COEF_FIRST_ADDR
		&& coef_addr_reg <= COEF_LAST_ADDR;
	assign coef_idx = 5'(coef_addr_reg - COEF_FIRST_ADDR);

	function automatic logic [7:0] read_value(input logic [6:0] a);
		logic [5:0] coef;
		coef = cal_ctrl_reg[CTRL_SEL_I_BIT] ? coef_i_mem[coef_idx]
			: coef_q_mem[coef_idx];
		if (a == REG_I_FINE_GAIN)        return i_fine_reg;
		else if (a == REG_I_COARSE_GAIN) return i_coarse_reg;
		else if (a == REG_I_CM_RES)      return i_cm_reg;
		else if (a == REG_Q_FINE_GAIN)   return q_fine_reg;
		else if (a == REG_Q_COARSE_GAIN) return q_coarse_reg;
		else if (a == REG_Q_CM_RES)      return q_cm_reg;
		else if (a == REG_REF_TRIM)      return trim_reg;
		else if (a == REG_CAL_CONTROL)   return cal_ctrl_reg;
		else if (a == REG_CAL_STATUS)
			return {done_q, done_i, 6'h00};
		else if (a == REG_COEF_ADDRESS)  return coef_addr_reg;
		else if (a == REG_COEF_DATA)
		begin
			// I wins when both channels are selected
			if (mem_ctrl_reg[MEM_READ_BIT] && coef_addr_ok)
				return {2'b00, coef};
			return 8'h00;
		end
		else if (a == REG_CAL_MEM_CTRL)  return {3'b000, mem_ctrl_reg};
		return 8'h00;
	endfunction

	// Serial port: sample on rising sclk, shift out on falling sclk
	always_comb
	begin
		bit_cnt_next = bit_cnt_reg;
		shift_next   = shift_reg;
		addr_next    = addr_reg;
		rd_next      = rd_reg;
		tx_next      = tx_reg;
		sdo_next     = sdo_reg;
		oe_next      = oe_reg;
		wr_stb       = 1'b0;
		wr_data      = {shift_reg, sdio_s};
		if (cs_n_s)
		begin
			bit_cnt_next = 5'h00;
			oe_next      = 1'b0;
		end
		else if (sclk_rise && bit_cnt_reg < SPI_FRAME_BITS)
		begin
			shift_next   = {shift_reg[5:0], sdio_s};
			bit_cnt_next = bit_cnt_reg + 5'h01;
			if (bit_cnt_reg == SPI_HEADER_BITS - 5'h01)
			begin
				rd_next   = shift_reg[6];
				addr_next = {shift_reg[5:0], sdio_s};
				tx_next   = read_value({shift_reg[5:0], sdio_s});
			end
			if (bit_cnt_reg == SPI_FRAME_BITS - 5'h01 && !rd_reg)
				wr_stb = 1'b1;
		end
		else if (sclk_fall && rd_reg && bit_cnt_reg >= SPI_HEADER_BITS)
		begin
			if (bit_cnt_reg < SPI_FRAME_BITS)
			begin
				sdo_next = tx_reg[7];
				tx_next  = {tx_reg[6:0], 1'b0};
				oe_next  = 1'b1;
			end
			else
				oe_next = 1'b0;
		end
	end

	// Register writes; hardware sets of uncalibrated flags win over clears
	always_comb
	begin
		i_fine_next    = i_fine_reg;
		i_coarse_next  = i_coarse_reg;
		i_cm_next      = i_cm_reg;
		q_fine_next    = q_fine_reg;
		q_coarse_next  = q_coarse_reg;
		q_cm_next      = q_cm_reg;
		trim_next      = trim_reg;
		cal_ctrl_next  = cal_ctrl_reg;
		coef_addr_next = coef_addr_reg;
		mem_ctrl_next  = mem_ctrl_reg;
		if (wr_stb)
		begin
			if (addr_reg == REG_I_FINE_GAIN)        i_fine_next = wr_data;
			else if (addr_reg == REG_I_COARSE_GAIN) i_coarse_next = wr_data;
			else if (addr_reg == REG_I_CM_RES)      i_cm_next = wr_data;
			else if (addr_reg == REG_Q_FINE_GAIN)   q_fine_next = wr_data;
			else if (addr_reg == REG_Q_COARSE_GAIN) q_coarse_next = wr_data;
			else if (addr_reg == REG_Q_CM_RES)      q_cm_next = wr_data;
			else if (addr_reg == REG_REF_TRIM)      trim_next = wr_data;
			else if (addr_reg == REG_CAL_CONTROL)   cal_ctrl_next = wr_data;
			else if (addr_reg == REG_COEF_ADDRESS)  coef_addr_next = wr_data;
			else if (addr_reg == REG_CAL_MEM_CTRL)
			begin
				// Flag bits only clear; they are never set by software
				mem_ctrl_next[4:2] = wr_data[4:2];
				mem_ctrl_next[1:0] = mem_ctrl_reg[1:0] & wr_data[1:0];
			end
		end
		if (abort_i)
			mem_ctrl_next[MEM_UNCAL_I_BIT] = 1'b1;
		if (abort_q)
			mem_ctrl_next[MEM_UNCAL_Q_BIT] = 1'b1;
	end

	// Divider: period is 32 << select, clamped at 2048
	assign period   = div_period(cal_ctrl_reg[CTRL_DIV_MSB:0]);
	assign cal_tick = cal_ctrl_reg[CTRL_CLK_EN_BIT]
		&& {1'b0, div_cnt_reg} >= period - 12'h001;

	always_comb
	begin
		if (!cal_ctrl_reg[CTRL_CLK_EN_BIT] || cal_tick)
			div_cnt_next = 11'h000;
		else
			div_cnt_next = div_cnt_reg + 11'h001;
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			i_fine_reg    <= REG_RESET;
			i_coarse_reg  <= REG_RESET;
			i_cm_reg      <= REG_RESET;
			q_fine_reg    <= REG_RESET;
			q_coarse_reg  <= REG_RESET;
			q_cm_reg      <= REG_RESET;
			trim_reg      <= REG_RESET;
			cal_ctrl_reg  <= REG_RESET;
			coef_addr_reg <= REG_RESET;
			mem_ctrl_reg  <= 5'h00;
			bit_cnt_reg   <= 5'h00;
			shift_reg     <= 7'h00;
			addr_reg      <= 7'h00;
			rd_reg        <= 1'b0;
			tx_reg        <= 8'h00;
			sdo_reg       <= 1'b0;
			oe_reg        <= 1'b0;
			div_cnt_reg   <= 11'h000;
		end
		else
		begin
			i_fine_reg    <= i_fine_next;
			i_coarse_reg  <= i_coarse_next;
			i_cm_reg      <= i_cm_next;
			q_fine_reg    <= q_fine_next;
			q_coarse_reg  <= q_coarse_next;
			q_cm_reg      <= q_cm_next;
			trim_reg      <= trim_next;
			cal_ctrl_reg  <= cal_ctrl_next;
			coef_addr_reg <= coef_addr_next;
			mem_ctrl_reg  <= mem_ctrl_next;
			bit_cnt_reg   <= bit_cnt_next;
			shift_reg     <= shift_next;
			addr_reg      <= addr_next;
			rd_reg        <= rd_next;
			tx_reg        <= tx_next;
			sdo_reg       <= sdo_next;
			oe_reg        <= oe_next;
			div_cnt_reg   <= div_cnt_next;
		end
	end

	// Host writes go to every selected channel; engine stores take priority
	assign host_wr_i = wr_stb && addr_reg == REG_COEF_DATA && coef_addr_ok
		&& mem_ctrl_reg[MEM_WRITE_BIT]
		&& cal_ctrl_reg[CTRL_SEL_I_BIT];
	assign host_wr_q = wr_stb && addr_reg == REG_COEF_DATA && coef_addr_ok
		&& mem_ctrl_reg[MEM_WRITE_BIT]
		&& cal_ctrl_reg[CTRL_SEL_Q_BIT];

	always_ff @(posedge ref_clk_in)
	begin
		if (eng_wr_i)
			coef_i_mem[eng_idx_i] <= eng_data_i;
		else if (host_wr_i)
			coef_i_mem[coef_idx] <= wr_data[COEF_W-1:0];
		if (eng_wr_q)
			coef_q_mem[eng_idx_q] <= eng_data_q;
		else if (host_wr_q)
			coef_q_mem[coef_idx] <= wr_data[COEF_W-1:0];
	end

	// One engine per channel, sharing the calibration tick
	cal_engine u_engine_i
	(
		.clk_in        (ref_clk_in),
		.rstn_in       (rstn_in),
		.cal_tick_in   (cal_tick),
		.start_in      (mem_ctrl_reg[MEM_START_BIT]),
		.select_in     (cal_ctrl_reg[CTRL_SEL_I_BIT]),
		.comparator_in (sync2_reg[3]),
		.busy_out      (),
		.done_out      (done_i),
		.abort_out     (abort_i),
		.coef_wr_out   (eng_wr_i),
		.coef_idx_out  (eng_idx_i),
		.coef_data_out (eng_data_i)
	);

	cal_engine u_engine_q
	(
		.clk_in        (ref_clk_in),
		.rstn_in       (rstn_in),
		.cal_tick_in   (cal_tick),
		.start_in      (mem_ctrl_reg[MEM_START_BIT]),
		.select_in     (cal_ctrl_reg[CTRL_SEL_Q_BIT]),
		.comparator_in (sync2_reg[4]),
		.busy_out      (),
		.done_out      (done_q),
		.abort_out     (abort_q),
		.coef_wr_out   (eng_wr_q),
		.coef_idx_out  (eng_idx_q),
		.coef_data_out (eng_data_q)
	);

	assign spi_sdio_out                  = sdo_reg;
	assign spi_sdio_oe_out               = oe_reg;
	assign i_fine_gain_code_out          = i_fine_reg[5:0];
	assign i_coarse_gain_code_out        = i_coarse_reg[5:0];
	assign i_common_mode_res_code_out    = i_cm_reg[5:0];
	assign i_common_mode_res_connect_out = i_cm_reg[CM_CONNECT_BIT];
	assign q_fine_gain_code_out          = q_fine_reg[5:0];
	assign q_coarse_gain_code_out        = q_coarse_reg[5:0];
	assign q_common_mode_res_code_out    = q_cm_reg[5:0];
	assign q_common_mode_res_connect_out = q_cm_reg[CM_CONNECT_BIT];
	assign reference_trim_code_out       = trim_reg[5:0];

	// Cycles since the last tick, seen only by the checks below
	logic [11:0] since_tick_reg;
	logic        tick_seen_reg;
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			since_tick_reg <= 12'h000;
			tick_seen_reg  <= 1'b0;
		end
		else if (cal_tick)
		begin
			since_tick_reg <= 12'h000;
			tick_seen_reg  <= 1'b1;
		end
		else if (since_tick_reg != 12'hFFF)
			since_tick_reg <= since_tick_reg + 12'h001;
	end

	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);

	property p_tick_needs_enable;
		cal_tick |-> cal_ctrl_reg[CTRL_CLK_EN_BIT];
	endproperty
	a_tick_needs_enable: assert property (p_tick_needs_enable)
		else $error("Calibration tick while clock disabled");

	property p_tick_spacing;
		cal_tick && tick_seen_reg |-> since_tick_reg >= 12'h01F;
	endproperty
	a_tick_spacing: assert property (p_tick_spacing)
		else $error("Calibration ticks closer than 32 cycles");

	property p_clear_mem_ctrl;
		wr_stb && addr_reg == REG_CAL_MEM_CTRL && wr_data == 8'h00
			&& !abort_i && !abort_q |=> mem_ctrl_reg == 5'h00;
	endproperty
	a_clear_mem_ctrl: assert property (p_clear_mem_ctrl)
		else $error("Zero write left control bits set");

	property p_host_coef_write;
		host_wr_i && !eng_wr_i
			|=> coef_i_mem[$past(coef_idx)] == $past(wr_data[5:0]);
	endproperty
	a_host_coef_write: assert property (p_host_coef_write)
		else $error("Host coefficient write not stored");

	// Status byte is captured when the address of a read is complete
	property p_status_done;
		!cs_n_s && sclk_rise && bit_cnt_reg == SPI_HEADER_BITS - 5'h01
			&& {shift_reg[5:0], sdio_s} == REG_CAL_STATUS
			|=> tx_reg == {$past(done_q), $past(done_i), 6'h00};
	endproperty
	a_status_done: assert property (p_status_done)
		else $error("Status byte does not show completion");

	c_spi_read: cover property (sclk_fall && rd_reg && oe_next);
	c_host_write: cover property (host_wr_q);
	c_both_done: cover property (done_i && done_q);
endmodule

// file: host_model.sv
// Purpose: Host on the serial configuration port.
// Assumes: Six converter clocks per serial clock phase.
// Notes:   Releases sdio for the data byte of a read.
`timescale 1ns/100ps
module host_model
(
	input  wire logic clk_in,
	input  wire logic sdio_in,
	output logic      cs_n_out,
	output logic      sclk_out,
	output logic      sdio_out,
	output logic      oe_out
);
	initial
	begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		sdio_out = 1'b0;
		oe_out = 1'b0;
	end
	// Slow phases, since the pins are sampled late
	task automatic frame(input logic [15:0] w, output logic [7:0] q);
		@(posedge clk_in) cs_n_out <= 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			oe_out <= !(w[15] && i < 8);
			sdio_out <= w[i];
			repeat (6) @(posedge clk_in);
			sclk_out <= 1'b1;
			q[i % 8] = sdio_in;
			repeat (6) @(posedge clk_in);
			sclk_out <= 1'b0;
		end
		repeat (6) @(posedge clk_in);
		cs_n_out <= 1'b1;
		oe_out <= 1'b0;
		repeat (8) @(posedge clk_in);
	endtask
endmodule

// file: tb.sv
// Purpose: Self-checking bench for the calibration control block.
// Assumes: host_model drives the serial port.
// Notes:   Coefficients checked at four addresses to save run time.
`timescale 1ns/100ps
module tb;
	import dac_cal_pkg::*;
	logic       ref_clk_in = 1'b0;
	logic       rstn_in = 1'b0;
	logic       cs_n, sclk, h_sdio, h_oe, d_sdio, d_oe, con_i, con_q;
	logic       last = 1'b0;
	logic       cmp_i = 1'b0;
	logic       cmp_q = 1'b0;
	logic [5:0] cd [7];
	logic [6:0] ra [12] = '{7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08,
		7'h0D, 7'h0E, 7'h0F, 7'h10, 7'h11, 7'h12};
	logic [7:0] ca [4] = '{8'h01, 8'h20, 8'h02, 8'h13};
	logic [7:0] v [7];
	logic [7:0] cv [2][4];
	int         n_mismatch = 0;
	int         comparisons = 0;
	int         seed = 32'h6CF2;
	// A released line toggles so a stale bit cannot pass for data
	wire logic  sdio = d_oe ? d_sdio : h_oe ? h_sdio : !last;

	always #25 ref_clk_in = !ref_clk_in;
	always @(posedge ref_clk_in)
	begin
		last <= sdio;
		cmp_i <= 1'($random(seed));
		cmp_q <= 1'($random(seed));
	end

	host_model host (.clk_in(ref_clk_in), .sdio_in(sdio), .cs_n_out(cs_n),
		.sclk_out(sclk), .sdio_out(h_sdio), .oe_out(h_oe));
	dac_cal_ctrl dut (.ref_clk_in, .rstn_in, .spi_cs_n_in(cs_n),
		.spi_sclk_in(sclk), .spi_sdio_in(sdio), .spi_sdio_out(d_sdio),
		.spi_sdio_oe_out(d_oe), .cal_compare_i_in(cmp_i),
		.cal_compare_q_in(cmp_q), .i_fine_gain_code_out(cd[0]),
		.i_coarse_gain_code_out(cd[1]), .i_common_mode_res_code_out(cd[2]),
		.i_common_mode_res_connect_out(con_i), .q_fine_gain_code_out(cd[3]),
		.q_coarse_gain_code_out(cd[4]), .q_common_mode_res_code_out(cd[5]),
		.q_common_mode_res_connect_out(con_q),
		.reference_trim_code_out(cd[6]));

	function automatic logic [7:0] low6(input logic [7:0] x);
		return {2'h0, x[5:0]};
	endfunction
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("wrong value at %0t: %h expected %h", $time, s, e);
		end
	endtask
	task automatic w(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] q;
		host.frame({1'b0, a, d}, q);
	endtask
	task automatic r(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] q;
		host.frame({1'b1, a, 8'h00}, q);
		chk(q, e);
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		repeat (60000) @(posedge ref_clk_in);
		n_mismatch++;
		conclude;
	end

	initial
	begin
		repeat (5) @(posedge ref_clk_in);
		rstn_in <= 1'b1;
		repeat (4) @(posedge ref_clk_in);
		foreach (ra[i])
			r(ra[i], REG_RESET);
		chk({6'h00, con_i, con_q}, 8'h00);
		foreach (v[i])
		begin
			v[i] = 8'($random(seed));
			w(ra[i], v[i]);
		end
		foreach (v[i])
		begin
			r(ra[i], v[i]);
			chk({2'h0, cd[i]}, low6(v[i]));
		end
		chk({6'h00, con_i, con_q}, {6'h00, v[2][6], v[5][6]});
		w(REG_CAL_STATUS, 8'hFF);
		w(7'h7F, 8'hFF);
		r(REG_CAL_STATUS, 8'h00);
		r(7'h7F, 8'h00);
		foreach (cv[c])
		begin
			w(REG_CAL_CONTROL, c ? 8'h20 : 8'h10);
			w(REG_CAL_MEM_CTRL, 8'h08);
			foreach (ca[k])
			begin
				cv[c][k] = 8'($random(seed));
				w(REG_COEF_ADDRESS, ca[k]);
				w(REG_COEF_DATA, cv[c][k]);
			end
			w(REG_CAL_MEM_CTRL, 8'h00);
		end
		r(REG_COEF_DATA, 8'h00);
		foreach (cv[c])
		begin
			w(REG_CAL_CONTROL, c ? 8'h20 : 8'h10);
			foreach (ca[k])
			begin
				w(REG_COEF_ADDRESS, ca[k]);
				w(REG_CAL_MEM_CTRL, 8'h04);
				r(REG_COEF_DATA, low6(cv[c][k]));
				w(REG_CAL_MEM_CTRL, 8'h00);
			end
		end
		w(REG_CAL_MEM_CTRL, 8'h00);
		w(REG_CAL_CONTROL, 8'h08); // Divide by 32 gives 625 kHz
		w(REG_CAL_CONTROL, 8'h38);
		w(REG_CAL_MEM_CTRL, 8'h10);
		r(REG_CAL_STATUS, 8'h00);
		repeat (8600) @(posedge ref_clk_in);
		r(REG_CAL_STATUS, 8'h00);
		repeat (1000) @(posedge ref_clk_in);
		r(REG_CAL_STATUS, 8'hC0);
		w(REG_CAL_MEM_CTRL, 8'h00);
		r(REG_CAL_STATUS, 8'h00);
		r(REG_CAL_MEM_CTRL, 8'h00);
		// Paused run must not finish; stopping it marks both uncalibrated
		w(REG_CAL_MEM_CTRL, 8'h10);
		w(REG_CAL_CONTROL, 8'h30);
		repeat (10000) @(posedge ref_clk_in);
		r(REG_CAL_STATUS, 8'h00);
		w(REG_CAL_MEM_CTRL, 8'h00);
		r(REG_CAL_MEM_CTRL, 8'h03);
		w(REG_CAL_MEM_CTRL, 8'h00);
		r(REG_CAL_MEM_CTRL, 8'h00);
		w(REG_CAL_CONTROL, 8'h00);
		conclude;
	end
endmodule
